// ---- core/rsf_pkg.sv ----
// constants, types and register map of the receiver status and pin routing registers
// How it works
// - frequency offset shown read-only as 16-bit two's complement in high and low bytes
// - measure done reads 0 while measuring, 1 when result ready; resets to 1
// - writing 1 to trigger starts a measurement; trigger bit always reads 0
// - strength reading is 8-bit read-only, half-dB steps, resets to 0xFF
// - six 2-bit pin route fields reset to 00 at documented bit positions
// - 3-bit clock select: divide 1 to 32, 110 RC on, 111 off
// - mode reached sets when requested mode is ready, clears on change, resets 1
// - receive settled sets in receive after measure, gain, correction; clears leaving receive
// - bit 4 follows synth lock while in synthesis or receive mode
// - bit 3 sets when strength beats trigger level in receive; clears on exit or software
// - bit 2 sets on either receive timeout; clears leaving receive or fifo empty
// - bit 1 high while device sits in an intermediate mode
// - bit 0 sets on sync and address detect; clears leaving receive or fifo empty
// - sync match read-only in packet mode, write-one clearable in continuous mode
// - entry timeout after count times 16 bits without threshold; zero disables
// - payload timeout after count times 16 bits past threshold; zero disables
`default_nettype none
package rsf_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FREQ_ERROR_HIGH  = 8'h21;
  localparam logic [7:0] IDX_FREQ_ERROR_LOW   = 8'h22;
  localparam logic [7:0] IDX_SIGNAL_MEASURE   = 8'h23;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH  = 8'h24;
  localparam logic [7:0] IDX_PIN_ROUTE_FIRST  = 8'h25;
  localparam logic [7:0] IDX_PIN_ROUTE_SECOND = 8'h26;
  localparam logic [7:0] IDX_EVENT_STATUS     = 8'h27;
  localparam logic [7:0] IDX_TRIGGER_LEVEL    = 8'h29;
  localparam logic [7:0] IDX_ENTRY_TIMEOUT    = 8'h2A;
  localparam logic [7:0] IDX_PAYLOAD_TIMEOUT  = 8'h2B;
  localparam logic [7:0] IDX_IRQ_STATUS       = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK         = 8'h41;
  // field positions
  localparam int BIT_MEASURE_DONE    = 1;
  localparam int BIT_MEASURE_TRIGGER = 0;
  localparam int BIT_MODE_REACHED    = 7;
  localparam int BIT_RX_SETTLED      = 6;
  localparam int BIT_SYNTH_LOCKED    = 4;
  localparam int BIT_THRESHOLD       = 3;
  localparam int BIT_TIMEOUT         = 2;
  localparam int BIT_INTERMEDIATE    = 1;
  localparam int BIT_SYNC_MATCH      = 0;
  localparam logic [7:0] STATUS_USED_MASK = 8'hDF;
  // reset values
  localparam logic [7:0] RST_STRENGTH      = 8'hFF;
  localparam logic [7:0] RST_TRIGGER_LEVEL = 8'hE4;
  localparam logic [7:0] RST_TIMEOUT       = 8'h00;
  localparam logic [7:0] RST_PIN_ROUTE     = 8'h00;
  localparam logic [2:0] RST_CLOCK_SEL     = 3'h7;
  localparam logic [7:0] RST_IRQ_MASK      = 8'h00;
  // timing
  localparam int BITS_PER_TIMEOUT_STEP = 16;
  // clock output select codes
  localparam logic [2:0] CLK_SEL_RC  = 3'h6;
  localparam logic [2:0] CLK_SEL_OFF = 3'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_RECEIVE} rsf_mode_e;

  // status fed from the rest of the receiver core, all on core_clk
  typedef struct packed {
    rsf_mode_e   mode;
    logic        intermediate;
    logic        xo_running;
    logic        pll_locked;
    logic        rx_sampling;
    logic        gain_freq_done;
    logic        strength_valid;
    logic [7:0]  strength_value;
    logic        freq_err_valid;
    logic [15:0] freq_err_value;
    logic        sync_detect;
    logic        payload_ready;
    logic        fifo_empty;
    logic        packet_mode;
    logic        bit_tick;
  } rsf_radio_s;

  // clock output control toward the clock output pad logic
  typedef struct packed {
    logic       enable;
    logic       rc_osc_en;
    logic [2:0] div_log2;
  } rsf_clock_output_select_s;
endpackage : rsf_pkg
`default_nettype wire

// ---- core/rsf_top.sv ----
// status flag, signal measure, pin routing and clock select registers with axi4-lite slave
`default_nettype none
module rsf_top #(
  parameter int PINS = 6
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // axi4-lite slave
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // receiver core
  input  wire rsf_pkg::rsf_radio_s   radio,
  input  wire logic [PINS*4-1:0]     pin_evt_cont,
  input  wire logic [PINS*4-1:0]     pin_evt_pkt,
  output logic                       signal_measure_trigger,
  // pins and clock output control
  output logic [PINS-1:0]            pin_out,
  output rsf_pkg::rsf_clock_output_select_s       clock_output_select_ctrl,
  // interrupt
  output logic                       irq
);
  import rsf_pkg::*;

  logic [7:0]  route_first_q;
  logic [7:0]  route_second_q;
  logic [2:0]  clock_output_select_q;
  logic [7:0]  signal_trigger_level_q;
  logic [7:0]  entry_timeout_count_q;
  logic [7:0]  payload_timeout_count_q;
  logic [15:0] freq_error_value_q;
  logic [7:0]  signal_strength_reading_q;
  logic        signal_measure_done_q;
  logic        mode_reached_flag_q;
  logic        receive_settled_flag_q;
  logic        synth_locked_flag_q;
  logic        threshold_flag_q;
  logic        timeout_flag_q;
  logic        intermediate_state_flag_q;
  logic        sync_match_flag_q;
  logic [7:0]  irq_status_q;
  logic [7:0]  irq_mask_q;
  logic [7:0]  flags_prev_q;
  rsf_mode_e   mode_prev_q;
  logic        in_rx_q;
  logic        payload_wait_q;
  logic [11:0] timeout_cnt_q;
  logic [7:0]  flags;
  logic        rx_entry;
  logic        leave_rx;

  // ---------------- axi4-lite write channel ----------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_idx_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_byte;
  logic        wr_ok;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q;
  assign wr_idx        = aw_idx_q;
  assign wr_byte       = wdata_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (wr_idx)
      IDX_FREQ_ERROR_HIGH, IDX_FREQ_ERROR_LOW, IDX_SIGNAL_MEASURE, IDX_SIGNAL_STRENGTH,
      IDX_PIN_ROUTE_FIRST, IDX_PIN_ROUTE_SECOND, IDX_EVENT_STATUS, IDX_TRIGGER_LEVEL,
      IDX_ENTRY_TIMEOUT, IDX_PAYLOAD_TIMEOUT, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // strobe of a write that actually reaches a register's low byte
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_fire && wlane_q && (wr_idx == idx);
  endfunction : wr_hit

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      route_first_q           <= RST_PIN_ROUTE;
      route_second_q          <= RST_PIN_ROUTE;
      clock_output_select_q   <= RST_CLOCK_SEL;
      signal_trigger_level_q  <= RST_TRIGGER_LEVEL;
      entry_timeout_count_q   <= RST_TIMEOUT;
      payload_timeout_count_q <= RST_TIMEOUT;
      irq_mask_q              <= RST_IRQ_MASK;
    end
    else
    begin
      if (wr_hit(IDX_PIN_ROUTE_FIRST))
        route_first_q <= wr_byte;
      if (wr_hit(IDX_PIN_ROUTE_SECOND))
      begin
        route_second_q        <= {wr_byte[7:4], 4'h0};
        clock_output_select_q <= wr_byte[2:0];
      end
      if (wr_hit(IDX_TRIGGER_LEVEL))
        signal_trigger_level_q <= wr_byte;
      if (wr_hit(IDX_ENTRY_TIMEOUT))
        entry_timeout_count_q <= wr_byte;
      if (wr_hit(IDX_PAYLOAD_TIMEOUT))
        payload_timeout_count_q <= wr_byte;
      if (wr_hit(IDX_IRQ_MASK))
        irq_mask_q <= wr_byte & STATUS_USED_MASK;
    end
  end

  // clock output decode
  always_comb
  begin
    clock_output_select_ctrl.enable    = (clock_output_select_q != CLK_SEL_OFF);
    clock_output_select_ctrl.rc_osc_en = (clock_output_select_q == CLK_SEL_RC);
    clock_output_select_ctrl.div_log2  = (clock_output_select_q < CLK_SEL_RC) ? clock_output_select_q : 3'h0;
  end

  // ---------------- measurement results ----------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      signal_measure_trigger    <= 1'b0;
      signal_measure_done_q     <= 1'b1;
      signal_strength_reading_q <= RST_STRENGTH;
      freq_error_value_q        <= 16'h0000;
    end
    else
    begin
      // trigger is a one-cycle pulse, never stored as a readable bit
      signal_measure_trigger <= wr_hit(IDX_SIGNAL_MEASURE) && wr_byte[BIT_MEASURE_TRIGGER];
      if (radio.strength_valid)
      begin
        signal_measure_done_q     <= 1'b1;
        signal_strength_reading_q <= radio.strength_value;
      end
      else if (signal_measure_trigger)
        signal_measure_done_q <= 1'b0;
      if (radio.freq_err_valid)
        freq_error_value_q <= radio.freq_err_value;
    end
  end

  // ---------------- mode tracking and timeouts ----------------
  assign rx_entry = (radio.mode == MODE_RECEIVE) && !in_rx_q;
  assign leave_rx = in_rx_q && (radio.mode != MODE_RECEIVE);

  logic [11:0] entry_limit;
  logic [11:0] payload_limit;
  logic        timeout_hit;
  assign entry_limit   = 12'(entry_timeout_count_q) * 12'(BITS_PER_TIMEOUT_STEP);
  assign payload_limit = 12'(payload_timeout_count_q) * 12'(BITS_PER_TIMEOUT_STEP);
  assign timeout_hit   = in_rx_q && radio.bit_tick &&
                         (payload_wait_q ? (payload_limit != 12'h000 &&
                                            timeout_cnt_q + 12'h001 == payload_limit)
                                         : (!threshold_flag_q && entry_limit != 12'h000 &&
                                            timeout_cnt_q + 12'h001 == entry_limit));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      in_rx_q        <= 1'b0;
      mode_prev_q    <= MODE_STANDBY;
      payload_wait_q <= 1'b0;
      timeout_cnt_q  <= 12'h000;
    end
    else
    begin
      in_rx_q     <= (radio.mode == MODE_RECEIVE);
      mode_prev_q <= radio.mode;
      if (rx_entry || leave_rx)
      begin
        payload_wait_q <= 1'b0;
        timeout_cnt_q  <= 12'h000;
      end
      else if (in_rx_q && !payload_wait_q && flags[BIT_THRESHOLD] && !threshold_flag_q)
      begin
        // threshold event restarts the count for the payload wait
        payload_wait_q <= 1'b1;
        timeout_cnt_q  <= 12'h000;
      end
      else if (payload_wait_q && radio.payload_ready)
        payload_wait_q <= 1'b0;
      else if (timeout_hit)
        timeout_cnt_q <= 12'h000;
      else if (in_rx_q && radio.bit_tick)
        timeout_cnt_q <= timeout_cnt_q + 12'h001;
    end
  end

  // ---------------- event status flags ----------------
  logic status_wr;
  logic mode_change;
  logic mode_ready_now;
  assign status_wr   = wr_hit(IDX_EVENT_STATUS);
  assign mode_change = (radio.mode != mode_prev_q);

  always_comb
  begin
    unique case (radio.mode)
      MODE_SLEEP:   mode_ready_now = 1'b1;
      MODE_STANDBY: mode_ready_now = radio.xo_running;
      MODE_SYNTH:   mode_ready_now = radio.pll_locked;
      MODE_RECEIVE: mode_ready_now = radio.rx_sampling;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mode_reached_flag_q       <= 1'b1;
      receive_settled_flag_q    <= 1'b0;
      synth_locked_flag_q       <= 1'b0;
      threshold_flag_q          <= 1'b0;
      timeout_flag_q            <= 1'b0;
      intermediate_state_flag_q <= 1'b0;
      sync_match_flag_q         <= 1'b0;
    end
    else
    begin
      mode_reached_flag_q <= !mode_change && mode_ready_now;
      receive_settled_flag_q <= (radio.mode == MODE_RECEIVE) && radio.rx_sampling &&
                                signal_measure_done_q && radio.gain_freq_done;
      synth_locked_flag_q <= ((radio.mode == MODE_SYNTH) || (radio.mode == MODE_RECEIVE)) &&
                             radio.pll_locked;
      intermediate_state_flag_q <= radio.intermediate;
      // set wins over a software clear in the same cycle
      if (leave_rx)
        threshold_flag_q <= 1'b0;
      else if (in_rx_q && signal_measure_done_q &&
               signal_strength_reading_q < signal_trigger_level_q)
        threshold_flag_q <= 1'b1;
      else if (status_wr && wr_byte[BIT_THRESHOLD])
        threshold_flag_q <= 1'b0;
      if (leave_rx)
        timeout_flag_q <= 1'b0;
      else if (timeout_hit)
        timeout_flag_q <= 1'b1;
      else if (radio.fifo_empty)
        timeout_flag_q <= 1'b0;
      if (leave_rx)
        sync_match_flag_q <= 1'b0;
      else if (in_rx_q && radio.sync_detect)
        sync_match_flag_q <= 1'b1;
      else if (radio.fifo_empty)
        sync_match_flag_q <= 1'b0;
      else if (status_wr && wr_byte[BIT_SYNC_MATCH] && !radio.packet_mode)
        sync_match_flag_q <= 1'b0;
    end
  end

  // stronger signal gives a smaller magnitude, so exceeding means reading below level
  always_comb
  begin
    flags                   = 8'h00;
    flags[BIT_MODE_REACHED] = mode_reached_flag_q;
    flags[BIT_RX_SETTLED]   = receive_settled_flag_q;
    flags[BIT_SYNTH_LOCKED] = synth_locked_flag_q;
    flags[BIT_THRESHOLD]    = (in_rx_q && signal_measure_done_q &&
                               signal_strength_reading_q < signal_trigger_level_q) ||
                              threshold_flag_q;
    flags[BIT_TIMEOUT]      = timeout_flag_q;
    flags[BIT_INTERMEDIATE] = intermediate_state_flag_q;
    flags[BIT_SYNC_MATCH]   = sync_match_flag_q;
  end

  // ---------------- interrupt ----------------
  logic [7:0] flag_rise;
  assign flag_rise = flags & ~flags_prev_q & STATUS_USED_MASK;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flags_prev_q <= 8'h00;
      irq_status_q <= 8'h00;
    end
    else
    begin
      flags_prev_q <= flags;
      // a rising flag beats a write-one clear of the same bit
      irq_status_q <= (irq_status_q & ~((wr_hit(IDX_IRQ_STATUS)) ? wr_byte : 8'h00))
                      | flag_rise;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ---------------- pin routing ----------------
  logic [2*PINS-1:0] route_sel;
  assign route_sel = {route_second_q[5:4], route_second_q[7:6], route_first_q[1:0],
                      route_first_q[3:2], route_first_q[5:4], route_first_q[7:6]};

  for (genvar p = 0; p < PINS; p++)
  begin : g_pin
    logic [3:0] evts;
    assign evts = radio.packet_mode ? pin_evt_pkt[p*4 +: 4] : pin_evt_cont[p*4 +: 4];
    always_ff @(posedge core_clk)
    begin
      if (rst)
        pin_out[p] <= 1'b0;
      else
        pin_out[p] <= evts[route_sel[p*2 +: 2]];
    end
  end

  // ---------------- axi4-lite read channel ----------------
  logic [7:0] rd_byte;
  logic       rd_ok;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    unique case (s_axi_araddr[9:2])
      IDX_FREQ_ERROR_HIGH:  rd_byte = freq_error_value_q[15:8];
      IDX_FREQ_ERROR_LOW:   rd_byte = freq_error_value_q[7:0];
      IDX_SIGNAL_MEASURE:   rd_byte = {6'h00, signal_measure_done_q, 1'b0};
      IDX_SIGNAL_STRENGTH:  rd_byte = signal_strength_reading_q;
      IDX_PIN_ROUTE_FIRST:  rd_byte = route_first_q;
      IDX_PIN_ROUTE_SECOND: rd_byte = {route_second_q[7:4], 1'b0, clock_output_select_q};
      IDX_EVENT_STATUS:     rd_byte = flags;
      IDX_TRIGGER_LEVEL:    rd_byte = signal_trigger_level_q;
      IDX_ENTRY_TIMEOUT:    rd_byte = entry_timeout_count_q;
      IDX_PAYLOAD_TIMEOUT:  rd_byte = payload_timeout_count_q;
      IDX_IRQ_STATUS:       rd_byte = irq_status_q;
      IDX_IRQ_MASK:         rd_byte = irq_mask_q;
      default:              rd_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule : rsf_top
`default_nettype wire

// ---- verification/rsf_monitor.sv ----
// port level assertions for the status and pin routing register block
`default_nettype none
module rsf_monitor
  import rsf_pkg::*;
#(
  parameter int PINS = 6
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // bus handshakes
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata,
  // core side
  input wire logic                 signal_measure_trigger,
  input wire logic [PINS-1:0]      pin_out,
  input wire rsf_pkg::rsf_clock_output_select_s clock_output_select_ctrl,
  input wire logic                 irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_trig_pulse:
    assert property (signal_measure_trigger |=> !signal_measure_trigger)
    else $error("trigger longer than one cycle");
  a_reset_quiet:
    assert property ($fell(rst) |-> pin_out == '0 && !irq && !clock_output_select_ctrl.enable)
    else $error("outputs not idle after reset");
  a_rc_select:
    assert property (clock_output_select_ctrl.rc_osc_en |-> clock_output_select_ctrl.enable && clock_output_select_ctrl.div_log2 == 3'h0)
    else $error("rc select not clean");
  a_clock_off:
    assert property (!clock_output_select_ctrl.enable |-> !clock_output_select_ctrl.rc_osc_en && clock_output_select_ctrl.div_log2 == 3'h0)
    else $error("clock off not clean");
  a_read_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_once:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_write_once:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_block:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  a_read_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  c_trig: cover property (signal_measure_trigger);
  c_irq: cover property ($rose(irq));
  c_rc: cover property (clock_output_select_ctrl.rc_osc_en);
endmodule : rsf_monitor
bind rsf_top rsf_monitor #(.PINS(PINS)) u_monitor (
  .core_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .signal_measure_trigger, .pin_out,
  .clock_output_select_ctrl, .irq
);
`default_nettype wire

// ---- verification/rsf_radio_model.sv ----
// behavioural receiver core feeding mode, measurement and event status
`default_nettype none
module rsf_radio_model
  import rsf_pkg::*;
(
  input  wire logic                core_clk,
  output var rsf_pkg::rsf_radio_s radio
);
  timeunit 1ns;
  timeprecision 1ps;
  initial radio = '0;
  task automatic go(input rsf_mode_e m, input logic lk, input logic im);
    @(posedge core_clk);
    radio.mode <= m;
    radio.xo_running <= 1'h1;
    radio.pll_locked <= lk;
    radio.rx_sampling <= (m == MODE_RECEIVE);
    radio.gain_freq_done <= (m == MODE_RECEIVE);
    radio.intermediate <= im;
  endtask : go
  task automatic meas(input logic [7:0] v, input logic [15:0] f);
    @(posedge core_clk);
    radio.strength_valid <= 1'h1;
    radio.strength_value <= v;
    radio.freq_err_valid <= 1'h1;
    radio.freq_err_value <= f;
    @(posedge core_clk);
    radio.strength_valid <= 1'h0;
    radio.freq_err_valid <= 1'h0;
  endtask : meas
  // one cycle event pulses
  task automatic pulse(input logic s, input logic f, input logic p = 1'h0);
    @(posedge core_clk);
    radio.sync_detect <= s;
    radio.fifo_empty <= f;
    radio.payload_ready <= p;
    @(posedge core_clk);
    radio.sync_detect <= 1'h0;
    radio.fifo_empty <= 1'h0;
    radio.payload_ready <= 1'h0;
  endtask : pulse
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      radio.bit_tick <= 1'h1;
      @(posedge core_clk);
      radio.bit_tick <= 1'h0;
    end
  endtask : ticks
  task automatic pk(input logic b);
    @(posedge core_clk);
    radio.packet_mode <= b;
  endtask : pk
endmodule : rsf_radio_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the status and pin routing register block
`default_nettype none
module tb;
  import rsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [23:0] pin_evt_cont = 24'h121248, pin_evt_pkt = 24'hEDEDB7;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq, signal_measure_trigger;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  pin_out;
  rsf_radio_s  radio;
  rsf_clock_output_select_s clock_output_select_ctrl;
  int          mismatches = 0, checks_done = 0, cycles = 0;
  rsf_top #(.PINS(6)) dut (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .radio, .pin_evt_cont, .pin_evt_pkt, .signal_measure_trigger, .pin_out,
    .clock_output_select_ctrl, .irq
  );
  rsf_radio_model rm (.core_clk, .radio);
  always #5 core_clk = ~core_clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
    @(posedge core_clk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge core_clk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata & {24'h0, m}, {24'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic t_reset;
    rd(8'h23, 8'hFF, 8'h02);
    rd(8'h24, 8'hFF, 8'hFF);
    s_axi_wstrb <= 4'h0;
    wr(8'h25, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(8'h25, 8'hFF, 8'h00);
    rd(8'h26, 8'hFF, 8'h07);
    rd(8'h27, 8'hFF, 8'h80);
    wr(8'h24, 8'h00);
    rd(8'h24, 8'hFF, 8'hFF);
    wr(8'h30, 8'h55, RESP_SLVERR);
    rd(8'h30, 8'hFF, 8'h00, RESP_SLVERR);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_measure;
    wr(8'h23, 8'h01);
    repeat (3) @(posedge core_clk);
    rd(8'h23, 8'hFF, 8'h00);
    rm.meas(8'h50, 16'hFEDC);
    rd(8'h23, 8'hFF, 8'h02);
    rd(8'h24, 8'hFF, 8'h50);
    rd(8'h21, 8'hFF, 8'hFE);
    rd(8'h22, 8'hFF, 8'hDC);
    $display("t_measure done");
  endtask : t_measure
  task automatic t_route;
    int c;
    wr(8'h25, 8'hE4);
    for (c = 0; c < 8; c++)
    begin
      wr(8'h26, {5'h09, c[2:0]});
      rd(8'h26, 8'hFF, {5'h08, c[2:0]});
      chk({27'h0, clock_output_select_ctrl}, {27'h0, c != 7, c == 6, (c < 6) ? c[2:0] : 3'h0});
    end
    repeat (2) @(posedge core_clk);
    chk({26'h0, pin_out}, 32'h3F);
    rm.pk(1'h1);
    repeat (2) @(posedge core_clk);
    chk({26'h0, pin_out}, 32'h0);
    pin_evt_pkt <= ~pin_evt_pkt;
    repeat (2) @(posedge core_clk);
    chk({26'h0, pin_out}, 32'h3F);
    rm.pk(1'h0);
    pin_evt_cont <= ~pin_evt_cont;
    repeat (2) @(posedge core_clk);
    chk({26'h0, pin_out}, 32'h0);
    $display("t_route done");
  endtask : t_route
  task automatic t_rx;
    rm.go(MODE_RECEIVE, 1'h1, 1'h0);
    repeat (4) @(posedge core_clk);
    rd(8'h27, 8'hFF, 8'hD8);
    rm.meas(8'hFF, 16'h0000);
    wr(8'h27, 8'h00);
    rd(8'h27, 8'h08, 8'h08);
    wr(8'h27, 8'h08);
    rd(8'h27, 8'h08, 8'h00);
    rm.go(MODE_STANDBY, 1'h0, 1'h1);
    repeat (4) @(posedge core_clk);
    rd(8'h27, 8'hFF, 8'h82);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_timeout;
    rm.meas(8'hFF, 16'h0000);
    wr(8'h2A, 8'h01);
    rm.go(MODE_RECEIVE, 1'h1, 1'h0);
    rm.ticks(15);
    rd(8'h27, 8'h04, 8'h00);
    rm.ticks(1);
    rd(8'h27, 8'h04, 8'h04);
    rm.pulse(1'h0, 1'h1);
    rd(8'h27, 8'h04, 8'h00);
    rm.go(MODE_STANDBY, 1'h0, 1'h0);
    wr(8'h2A, 8'h00);
    wr(8'h2B, 8'h01);
    rm.go(MODE_RECEIVE, 1'h1, 1'h0);
    rm.meas(8'h10, 16'h0000);
    rm.ticks(15);
    rd(8'h27, 8'h04, 8'h00);
    rm.ticks(1);
    rd(8'h27, 8'h04, 8'h04);
    rm.pulse(1'h0, 1'h1, 1'h1);
    rm.ticks(16);
    rd(8'h27, 8'h04, 8'h00);
    rm.go(MODE_STANDBY, 1'h0, 1'h0);
    rd(8'h27, 8'h04, 8'h00);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_sync;
    rm.go(MODE_RECEIVE, 1'h1, 1'h0);
    wr(8'h41, 8'h01);
    rd(8'h41, 8'hFF, 8'h01);
    chk({31'h0, irq}, 32'h0);
    rm.pulse(1'h1, 1'h0);
    rd(8'h27, 8'h01, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(8'h27, 8'h01);
    rd(8'h27, 8'h01, 8'h00);
    wr(8'h40, 8'h01);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rm.pk(1'h1);
    rm.pulse(1'h1, 1'h0);
    wr(8'h27, 8'h01);
    rd(8'h27, 8'h01, 8'h01);
    rm.go(MODE_STANDBY, 1'h0, 1'h0);
    rd(8'h27, 8'h01, 8'h00);
    $display("t_sync done");
  endtask : t_sync
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_measure();
    t_route();
    t_rx();
    t_timeout();
    t_sync();
    end_sim();
  end
endmodule : tb
`default_nettype wire
